//--- rtl/burst4_pkg.sv
// constants shared by both ends of the burst-of-four dual-port sram link
// assumes one system clock; every link edge lasts at least one system cycle
package burst4_pkg;
  localparam int DATA_W        = 18;  // data bits per beat
  localparam int BYTE_W        = 9;   // bits gated by one byte enable
  localparam int BURST_LEN     = 4;   // fixed beats per burst
  localparam int BEAT_W        = 2;   // address bits taken by the burst counter
  localparam int ADDR_W        = 6;   // word address width of the array
  localparam int RD_FIRST_AGE  = 3;   // link edges from read command to first beat
  localparam int WR_FIRST_AGE  = 2;   // link edges from write command to first beat
  localparam int AGE_N         = RD_FIRST_AGE + BURST_LEN;  // tracked command ages
  localparam int RD_MAX_PEND   = 2;   // reads in flight at most
  localparam int FIFO_DEPTH    = 8;   // write words buffered in the controller
  localparam int CLK_PERIOD_NS = 50;  // system clock period
endpackage

//--- rtl/burst_link_if.sv
// link between the memory controller and the sram port model
// assumes the testbench resolves the read data wire from q and q_oe
`timescale 1ns/1ns
interface burst_link_if #(parameter int ADDR_W = burst4_pkg::ADDR_W);
  logic                          k;
  logic                          k_n;
  logic                          c;
  logic                          c_n;
  logic                          rd_sel_n;
  logic                          wr_sel_n;
  logic [ADDR_W-1:0]             addr;
  logic [burst4_pkg::DATA_W-1:0] d;
  logic                          byte_enable_lo_n;
  logic                          byte_enable_hi_n;
  logic [burst4_pkg::DATA_W-1:0] q;
  logic                          q_oe;

  modport dev (input k, k_n, c, c_n, rd_sel_n, wr_sel_n, addr, d,
               byte_enable_lo_n, byte_enable_hi_n, output q, q_oe);
  modport ctl (output k, k_n, c, c_n, rd_sel_n, wr_sel_n, addr, d,
               byte_enable_lo_n, byte_enable_hi_n, input q, q_oe);
endinterface

//--- rtl/sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; storage is flip-flops addressed by pointer
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = burst4_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wp;
    logic [PTR_W-1:0]            rp;
    logic [PTR_W:0]              cnt;
    logic                        in_ready;
    logic                        out_valid;
  } fifo_state_type;

  fifo_state_type r;
  fifo_state_type n;
  logic           push;
  logic           pop;

  // flags are rebuilt from the next count so both stay registered
  always_comb
  begin
    n    = r;
    push = i_in_valid & r.in_ready;
    pop  = i_out_ready & r.out_valid;
    if (push)
    begin
      n.mem[r.wp] = i_in_data;
      n.wp        = (r.wp == PTR_W'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop)
      n.rp = (r.rp == PTR_W'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    n.cnt       = r.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    n.in_ready  = (n.cnt != (PTR_W+1)'(DEPTH));
    n.out_valid = (n.cnt != '0);
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '{default: '0, in_ready: 1'b1};
    else
      r <= n;
  end

  assign o_in_ready  = r.in_ready;
  assign o_out_valid = r.out_valid;
  assign o_out_data  = r.mem[r.rp];
endmodule

//--- rtl/burst_sram_dev.sv
// device end: burst-of-four sram with separate read and write ports
// assumes link pins are synchronous to i_clock and each link edge
// (k or c changing level) lasts at least one system cycle
`timescale 1ns/1ns
module burst_sram_dev #(
  parameter int ADDR_W = burst4_pkg::ADDR_W
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  burst_link_if.dev link,
  output logic      o_rd_busy,
  output logic      o_wr_busy
);
  localparam int WORDS  = 1 << ADDR_W;
  localparam int BASE_W = ADDR_W - burst4_pkg::BEAT_W;
  localparam int AGE_N  = burst4_pkg::AGE_N;
  localparam int DW     = burst4_pkg::DATA_W;
  localparam int BW     = burst4_pkg::BYTE_W;

  typedef struct packed {
    logic                         k_prev;
    logic                         c_prev;
    logic                         rd_last;
    logic                         wr_last;
    logic [AGE_N-1:0]             rd_v;
    logic [AGE_N-1:0][BASE_W-1:0] rd_a;
    logic [AGE_N-1:0]             wr_v;
    logic [AGE_N-1:0][BASE_W-1:0] wr_a;
    logic [WORDS-1:0][DW-1:0]     mem;
    logic [DW-1:0]                q;
    logic                         q_oe;
    logic                         rd_busy;
    logic                         wr_busy;
  } dev_state_type;

  dev_state_type     r;
  dev_state_type     n;
  logic              k_edge;
  logic              k_rise;
  logic              out_edge;
  logic              rd_cmd;
  logic              wr_cmd;
  logic [ADDR_W-1:0] idx;

  // every action waits for a link edge, so a stopped clock freezes
  // the pipelines, the array and the read pins in place
  always_comb
  begin
    n        = r;
    idx      = '0;
    rd_cmd   = 1'b0;
    wr_cmd   = 1'b0;
    k_edge   = (link.k != r.k_prev);
    k_rise   = link.k & ~r.k_prev;
    // c pair held high hands output timing over to the k pair
    out_edge = (link.c & link.c_n) ? k_edge : (link.c != r.c_prev);
    n.k_prev = link.k;
    n.c_prev = link.c;

    // command ages advance by one on each k or k# rise
    if (k_edge)
    begin
      n.rd_v = {r.rd_v[AGE_N-2:0], 1'b0};
      n.rd_a = {r.rd_a[AGE_N-2:0], BASE_W'(0)};
      n.wr_v = {r.wr_v[AGE_N-2:0], 1'b0};
      n.wr_a = {r.wr_a[AGE_N-2:0], BASE_W'(0)};
    end

    // commands sampled on k rise only
    if (k_rise)
    begin
      rd_cmd    = ~link.rd_sel_n & ~r.rd_last;
      // one shared address: a read select on the same rise always blocks the write, even when the read itself is refused
      wr_cmd    = ~link.wr_sel_n & ~r.wr_last & link.rd_sel_n;
      n.rd_last = rd_cmd;
      n.wr_last = wr_cmd;
      n.rd_v[0] = rd_cmd;
      n.rd_a[0] = link.addr[ADDR_W-1:burst4_pkg::BEAT_W];
      n.wr_v[0] = wr_cmd;
      n.wr_a[0] = link.addr[ADDR_W-1:burst4_pkg::BEAT_W];
    end

    // write beats land at ages 2..5, each gated by its own enables
    if (k_edge)
    begin
      for (int a = burst4_pkg::WR_FIRST_AGE;
           a < burst4_pkg::WR_FIRST_AGE + burst4_pkg::BURST_LEN; a++)
      begin
        if (n.wr_v[a])
        begin
          idx = {n.wr_a[a], burst4_pkg::BEAT_W'(a - burst4_pkg::WR_FIRST_AGE)};
          if (!link.byte_enable_lo_n)
            n.mem[idx][BW-1:0] = link.d[BW-1:0];
          if (!link.byte_enable_hi_n)
            n.mem[idx][DW-1:BW] = link.d[DW-1:BW];
        end
      end
    end

    // read beats at ages 3..6; slots with no burst release the pins
    if (out_edge)
    begin
      n.q_oe = 1'b0;
      for (int a = burst4_pkg::RD_FIRST_AGE;
           a < burst4_pkg::RD_FIRST_AGE + burst4_pkg::BURST_LEN; a++)
      begin
        if (n.rd_v[a])
        begin
          idx    = {n.rd_a[a], burst4_pkg::BEAT_W'(a - burst4_pkg::RD_FIRST_AGE)};
          n.q    = r.mem[idx];
          n.q_oe = 1'b1;
        end
      end
    end

    n.rd_busy = |n.rd_v;
    n.wr_busy = |n.wr_v;
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '0;
    else
      r <= n;
  end

  assign link.q    = r.q;
  assign link.q_oe = r.q_oe;
  assign o_rd_busy = r.rd_busy;
  assign o_wr_busy = r.wr_busy;
endmodule

//--- rtl/burst_sram_ctl.sv
// controller end: drives link clocks, selects and write beats
// assumes the user side is synchronous; k toggles once per system cycle
// while running, so a link edge is one cycle and a k period is two
`timescale 1ns/1ns
module burst_sram_ctl #(
  parameter int ADDR_W = burst4_pkg::ADDR_W
) (
  input  wire logic                                         i_clock,
  input  wire logic                                         i_nrst,
  burst_link_if.ctl                                         link,
  input  wire logic                                         i_rd_valid,
  input  wire logic [ADDR_W-1:0]                            i_rd_addr,
  output logic                                              o_rd_ready,
  output logic [burst4_pkg::BURST_LEN*burst4_pkg::DATA_W-1:0] o_rd_data,
  output logic                                              o_rd_data_valid,
  input  wire logic                                         i_wr_valid,
  input  wire logic [ADDR_W+1+burst4_pkg::DATA_W:0]         i_wr_word,
  output logic                                              o_wr_ready,
  input  wire logic                                         i_stop_req,
  input  wire logic                                         i_single_clock,
  output logic                                              o_clock_stopped
);
  localparam int DW  = burst4_pkg::DATA_W;
  localparam int BL  = burst4_pkg::BURST_LEN;
  localparam int WW  = ADDR_W + 2 + DW;  // {addr, hi_n, lo_n, data}

  typedef struct packed {
    logic                k;
    logic                ran;
    logic                rd_sel_n;
    logic                wr_sel_n;
    logic [ADDR_W-1:0]   addr;
    logic [DW-1:0]       d;
    logic                be_lo_n;
    logic                be_hi_n;
    logic                rd_gap;
    logic [1:0]          rd_pend;
    logic                rd_ready;
    logic [BL-1:0][DW-1:0] cap;
    logic [1:0]          cap_cnt;
    logic [BL*DW-1:0]    rd_data;
    logic                rd_valid;
    logic [BL-1:0][WW-1:0] stg;
    logic [2:0]          stg_cnt;
    logic                wr_act;
    logic [2:0]          wr_age;
    logic                c_hi;
    logic                stopped;
  } ctl_state_type;

  ctl_state_type r;
  ctl_state_type n;
  logic          run;
  logic          rd_take;
  logic          wr_take;
  logic [1:0]    wr_beat;
  logic          f_valid;
  logic          f_ready;
  logic [WW-1:0] f_word;

  // write words wait here; the staging slot drains it only between bursts
  sync_fifo #(
    .WIDTH (WW),
    .DEPTH (burst4_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (o_wr_ready),
    .i_in_data   (i_wr_word),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  (f_word)
  );

  assign f_ready = (r.stg_cnt != 3'(BL)) & ~r.wr_act;

  always_comb
  begin
    n = r;
    wr_beat = 2'h0;
    // a read already handed over keeps the clock running, else it is lost
    rd_take = r.rd_ready & i_rd_valid;
    // clock stops only once every burst has finished
    run     = ~(i_stop_req & (r.rd_pend == 2'h0) & ~r.wr_act &
                (r.stg_cnt != 3'(BL)) & ~rd_take);
    wr_take = run & ~r.k & ~rd_take & (r.stg_cnt == 3'(BL)) & ~r.wr_act;
    n.ran     = run;
    n.stopped = ~run;
    n.c_hi    = i_single_clock;

    // fill the burst staging slot from the fifo
    if (f_ready & f_valid)
    begin
      n.stg[r.stg_cnt[1:0]] = f_word;
      n.stg_cnt             = r.stg_cnt + 3'h1;
    end

    if (run)
    begin
      n.k        = ~r.k;
      n.rd_sel_n = 1'b1;
      n.wr_sel_n = 1'b1;
      n.be_lo_n  = 1'b1;
      n.be_hi_n  = 1'b1;
      if (!r.k)
        n.rd_gap = 1'b0;
      // commands go out with the k rise
      if (rd_take)
      begin
        n.rd_sel_n = 1'b0;
        n.addr     = i_rd_addr;
        n.rd_gap   = 1'b1;
      end
      else if (wr_take)
      begin
        n.wr_sel_n = 1'b0;
        n.addr     = r.stg[0][WW-1:DW+2];
        n.wr_act   = 1'b1;
        n.wr_age   = 3'h0;
      end
      // write beats follow the command on edges 2..5
      if (r.wr_act)
      begin
        n.wr_age = r.wr_age + 3'h1;
        // first beat edge maps to staging slot 0
        wr_beat  = n.wr_age[1:0] - 2'(burst4_pkg::WR_FIRST_AGE);
        if (n.wr_age >= 3'(burst4_pkg::WR_FIRST_AGE))
        begin
          n.d       = r.stg[wr_beat][DW-1:0];
          n.be_lo_n = r.stg[wr_beat][DW];
          n.be_hi_n = r.stg[wr_beat][DW+1];
        end
        if (n.wr_age == 3'(burst4_pkg::WR_FIRST_AGE + BL - 1))
        begin
          n.wr_act  = 1'b0;
          n.stg_cnt = 3'h0;
        end
      end
    end

    // one beat per cycle after a running cycle; stale frozen data ignored
    n.rd_valid = 1'b0;
    if (r.ran & link.q_oe & (r.rd_pend != 2'h0))
    begin
      n.cap[r.cap_cnt] = link.q;
      n.cap_cnt        = r.cap_cnt + 2'h1;
      if (r.cap_cnt == 2'(BL - 1))
      begin
        n.rd_data  = {link.q, r.cap[2], r.cap[1], r.cap[0]};
        n.rd_valid = 1'b1;
      end
    end
    n.rd_pend = r.rd_pend + 2'(rd_take) - 2'(n.rd_valid);
    // ready only ahead of a k rise that is not right after a read
    n.rd_ready = run & n.k == 1'b0 & ~n.rd_gap &
                 (n.rd_pend != 2'(burst4_pkg::RD_MAX_PEND));
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '{default: '0, rd_sel_n: 1'b1, wr_sel_n: 1'b1,
             be_lo_n: 1'b1, be_hi_n: 1'b1};
    else
      r <= n;
  end

  // c pair follows k unless single clock mode holds both high
  assign link.k             = r.k;
  assign link.k_n           = ~r.k;
  assign link.c             = r.c_hi | r.k;
  assign link.c_n           = r.c_hi | ~r.k;
  assign link.rd_sel_n      = r.rd_sel_n;
  assign link.wr_sel_n      = r.wr_sel_n;
  assign link.addr          = r.addr;
  assign link.d             = r.d;
  assign link.byte_enable_lo_n = r.be_lo_n;
  assign link.byte_enable_hi_n = r.be_hi_n;
  assign o_rd_ready         = r.rd_ready;
  assign o_rd_data          = r.rd_data;
  assign o_rd_data_valid    = r.rd_valid;
  assign o_clock_stopped    = r.stopped;
endmodule

//--- test/burst_link_assertions.sv
// checker for the link that joins controller and device ends
// assumes it watches the one link where both parties are design code
`timescale 1ns/1ns
module burst_link_assertions (
  input wire logic                          i_clock,
  input wire logic                          i_nrst,
  input wire logic                          k,
  input wire logic                          k_n,
  input wire logic                          c,
  input wire logic                          c_n,
  input wire logic                          rd_sel_n,
  input wire logic                          wr_sel_n,
  input wire logic                          byte_enable_lo_n,
  input wire logic                          byte_enable_hi_n,
  input wire logic [burst4_pkg::DATA_W-1:0] q,
  input wire logic                          q_oe
);
  logic       k_r;
  logic [6:0] rd_hist_r;
  logic [5:0] wr_hist_r;
  logic       rd_take;
  logic       wr_take;
  // a command counts only at a k rise, as the device samples it
  assign rd_take = k && !k_r && !rd_sel_n;
  assign wr_take = k && !k_r && !wr_sel_n && rd_sel_n;
  // bit i remembers a command taken i+1 cycles back
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      k_r       <= 1'b0;
      rd_hist_r <= 7'h00;
      wr_hist_r <= 6'h00;
    end
    else
    begin
      k_r       <= k;
      rd_hist_r <= {rd_hist_r[5:0], rd_take};
      wr_hist_r <= {wr_hist_r[4:0], wr_take};
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // beats are registered at edges 3..6, so the pins show them one cycle later
  a_oe_read_window: assert property (q_oe == (|rd_hist_r[6:3]))
    else $error("read data enable outside beat slots");
  a_read_spacing: assert property (rd_take |=> rd_sel_n [*3])
    else $error("reads closer than every other k rise");
  a_write_spacing: assert property (wr_take |=> wr_sel_n [*3])
    else $error("writes closer than every other k rise");
  a_one_select: assert property (rd_sel_n || wr_sel_n)
    else $error("read and write selected together");
  a_select_on_rise: assert property (!(rd_sel_n && wr_sel_n) |-> k && !k_r)
    else $error("select low away from a k rise");
  // two quiet k cycles so the last edge's register update has landed
  a_stop_holds: assert property ((k == k_r) ##1 (k == k_r) |-> $stable(q) && $stable(q_oe))
    else $error("read port moved while the clock stood");
  a_enable_in_beat: assert property (!(byte_enable_lo_n && byte_enable_hi_n) |-> |wr_hist_r[4:1])
    else $error("byte enable outside write beats");
  a_clock_pair: assert property ((k_n != k) && ((c && c_n) || (c == k && c_n == k_n)))
    else $error("clock pair out of step");
  c_read: cover property (rd_take);
  c_write: cover property (wr_take);
  c_stop: cover property ((k == k_r) [*3]);
  c_single: cover property (c && c_n && rd_take);
endmodule

//--- test/tb_top.sv
// testbench: controller and device face each other on one link; a
// second device sits on a link driven by the bench against the spacing
`timescale 1ns/1ns
module tb_top;
  localparam logic [71:0] exp_mask = {18'h00000, 18'h3ffff, 18'h001ff, 18'h3fe00};
  logic        i_clock;
  logic        i_nrst;
  logic        rd_valid;
  logic [5:0]  rd_addr;
  logic        rd_ready;
  logic [71:0] rd_data;
  logic        rd_data_valid;
  logic        wr_valid;
  logic [25:0] wr_word;
  logic        wr_ready;
  logic        stop_req;
  logic        single_clock;
  logic        clock_stopped;
  logic        wr_busy_a;
  logic        wr_busy_b;
  logic        rd_busy_b;
  int          error_cnt;
  int          checks;
  burst_link_if la ();
  burst_link_if lb ();
  burst_sram_ctl burst_sram_ctl_inst (.i_clock(i_clock), .i_nrst(i_nrst), .link(la),
    .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .o_rd_ready(rd_ready), .o_rd_data(rd_data),
    .o_rd_data_valid(rd_data_valid), .i_wr_valid(wr_valid), .i_wr_word(wr_word),
    .o_wr_ready(wr_ready), .i_stop_req(stop_req), .i_single_clock(single_clock),
    .o_clock_stopped(clock_stopped));
  burst_sram_dev burst_sram_dev_inst (.i_clock(i_clock), .i_nrst(i_nrst), .link(la),
    .o_rd_busy(), .o_wr_busy(wr_busy_a));
  burst_sram_dev burst_sram_dev_inst_b (.i_clock(i_clock), .i_nrst(i_nrst), .link(lb),
    .o_rd_busy(rd_busy_b), .o_wr_busy(wr_busy_b));
  burst_link_assertions burst_link_assertions_inst (.i_clock(i_clock), .i_nrst(i_nrst),
    .k(la.k), .k_n(la.k_n), .c(la.c), .c_n(la.c_n), .rd_sel_n(la.rd_sel_n),
    .wr_sel_n(la.wr_sel_n), .byte_enable_lo_n(la.byte_enable_lo_n),
    .byte_enable_hi_n(la.byte_enable_hi_n), .q(la.q), .q_oe(la.q_oe));
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // bench link clock runs free; its c pair simply follows k
  assign lb.k_n = ~lb.k;
  assign lb.c   = lb.k;
  assign lb.c_n = ~lb.k;
  always @(posedge i_clock)
    lb.k <= i_nrst ? ~lb.k : 1'b0;
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic push(input logic [25:0] w);
    int n;
    @(posedge i_clock);
    wr_valid <= 1'b1;
    wr_word  <= w;
    for (n = 0; n < 60; n++)
    begin
      @(posedge i_clock);
      if (wr_ready === 1'b1) break;
    end
    wr_valid <= 1'b0;
    tmo(n);
  endtask
  // waits for the burst to reach the array so a later read cannot overtake it
  task automatic wburst(input logic [5:0] a, input logic [71:0] dat, input logic [7:0] en_n);
    int n;
    for (int j = 0; j < 4; j++)
      push({a, en_n[2*j+1], en_n[2*j], dat[18*j +: 18]});
    for (n = 0; n < 60 && wr_busy_a !== 1'b1; n++) @(posedge i_clock);
    for (; n < 60 && wr_busy_a !== 1'b0; n++) @(posedge i_clock);
    tmo(n);
  endtask
  task automatic rburst(input logic [5:0] a, output logic [71:0] got);
    int n;
    @(posedge i_clock);
    rd_valid <= 1'b1;
    rd_addr  <= a;
    for (n = 0; n < 60; n++)
    begin
      @(posedge i_clock);
      if (rd_ready === 1'b1) break;
    end
    rd_valid <= 1'b0;
    for (; n < 60 && rd_data_valid !== 1'b1; n++) @(posedge i_clock);
    tmo(n);
    got = rd_data;
  endtask
  // one command on the bench link, launched so that k rises with it
  task automatic cmd_b(input logic rn, input logic wn);
    @(posedge i_clock);
    if (lb.k !== 1'b0) @(posedge i_clock);
    lb.rd_sel_n <= rn;
    lb.wr_sel_n <= wn;
    @(posedge i_clock);
    lb.rd_sel_n <= 1'b1;
    lb.wr_sel_n <= 1'b1;
  endtask
  task automatic watch_b(output int oe, output int wb, output int rb, output logic [17:0] qor);
    oe  = 0;
    wb  = 0;
    rb  = 0;
    qor = 18'h0;
    repeat (12)
    begin
      @(posedge i_clock);
      oe += (lb.q_oe === 1'b1);
      wb += (wr_busy_b === 1'b1);
      rb += (rd_busy_b === 1'b1);
      qor |= (lb.q_oe === 1'b1) ? lb.q : 18'h0;
    end
  endtask
  initial
  begin
    logic [71:0] got;
    logic [17:0] qor;
    logic [17:0] qs;
    logic        ks;
    int          oe;
    int          wb;
    int          rb;
    int          n;
    error_cnt = 0;
    checks = 0;
    i_nrst = 1'b0;
    rd_valid = 1'b0;
    rd_addr = 6'h00;
    wr_valid = 1'b0;
    wr_word = 26'h0;
    stop_req = 1'b0;
    single_clock = 1'b0;
    lb.rd_sel_n = 1'b1;
    lb.wr_sel_n = 1'b1;
    lb.addr = 6'h00;
    lb.d = 18'h3ffff;
    lb.byte_enable_lo_n = 1'b0;
    lb.byte_enable_hi_n = 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    wburst(6'h04, {18'h2d00f, 18'h1c0a5, 18'h0b35a, 18'h3ffc3}, 8'h00);
    rburst(6'h04, got);
    chk(got === {18'h2d00f, 18'h1c0a5, 18'h0b35a, 18'h3ffc3}, "burst readback");
    wburst(6'h08, {4{18'h3ffff}}, 8'h00);
    wburst(6'h08, 72'h0, 8'h36);
    rburst(6'h08, got);
    chk(got === exp_mask, "byte enable merge");
    // a read held up while the clock stands must be refused
    stop_req <= 1'b1;
    for (n = 0; n < 60 && clock_stopped !== 1'b1; n++) @(posedge i_clock);
    tmo(n);
    qs = la.q;
    ks = la.k;
    rd_valid <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk(la.k === ks && la.q === qs && rd_ready === 1'b0, "stopped clock hold");
    rd_valid <= 1'b0;
    stop_req <= 1'b0;
    single_clock <= 1'b1;
    for (n = 0; n < 60 && !(la.c === 1'b1 && la.c_n === 1'b1); n++) @(posedge i_clock);
    tmo(n);
    rburst(6'h08, got);
    chk(got === exp_mask, "single clock readback");
    watch_b(oe, wb, rb, qor);
    chk(oe == 0 && rb == 0, "idle read port driven");
    cmd_b(1'b0, 1'b0);
    watch_b(oe, wb, rb, qor);
    chk(oe == 4 && wb == 0 && rb == 7, "dual select");
    cmd_b(1'b0, 1'b1);
    cmd_b(1'b0, 1'b1);
    watch_b(oe, wb, rb, qor);
    // an accepted second read would keep the port busy two cycles longer
    chk(oe == 4 && rb == 5 && qor === 18'h0, "back to back reads");
    end_sim();
  end
endmodule
